// File: core/alr_flag_cell.sv
`timescale 1ns/1ps
`default_nettype none

module alr_flag_cell #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,    // system clock
    input  wire logic rst,    // sync reset, high
    input  wire logic cond,   // fault condition present
    input  wire logic clr,    // read clear of a bit seen as one
    output logic      flag    // sticky flag
);

    logic flag_reg;
    logic flag_next;

    // set wins over read clear
    always_comb begin
        flag_next = cond | (flag_reg & ~clr);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_reg <= RST_VAL;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

endmodule // alr_flag_cell

`default_nettype wire

// File: core/alr_top.sv
// Summary of operation
// R1 - each led conversion overwrites live led code
// R2 - pwm falling edge copies live to on-snapshot
// R3 - pwm rising edge copies live to off-snapshot
// R4 - logic bias stored as 8-bit code
// R5 - fallback input 10-bit, low/high, drives reference
// R6 - die heat 10-bit across low and high
// R7 - low-half read latches both; host reads low first
// R8 - warning flag when heat exceeds threshold [9:2]
// R9 - switch overheat forces shutdown, sets shutdown flag
// R10 - link error sets serial link error flag
// R11 - watchdog expiry enters fallback, counts two-bit timeouts
// R12 - logic bias undervoltage resets all, sets power-cycle
// R13 - analog bias undervoltage stops switching, sets flag
// R14 - dimming undervoltage disables that channel only
// R15 - boot undervoltage: high off, low on, flag
// R16 - loop filter overvoltage flag, switching unchanged
// R17 - effective pwm is dim pin AND internal pwm
// R18 - status read clears flags no longer present
// R19 - power-cycle set at power-up, cleared reading third
// R20 - adc result strobe with source selects destination
`timescale 1ns/1ps
`default_nettype none

module alr_top
    import alr_pkg::*;
(
    input  wire logic             clk,          // 200 MHz system clock
    input  wire logic             rst,          // logic bias undervoltage
    input  wire logic             psel,         // apb select
    input  wire logic             penable,      // apb access phase
    input  wire logic             pwrite,       // apb direction
    input  wire logic [7:0]       paddr,        // apb byte address
    input  wire logic [31:0]      pwdata,       // apb write data
    output logic                  pready,       // apb ready
    output logic [31:0]           prdata,       // apb read data
    output logic                  pslverr,      // apb unmapped address
    input  wire alr_adc_s         adc_result,   // adc result and source
    input  wire alr_cmp_s         cmp_pins,     // raw comparator levels
    input  wire logic [1:0]       internal_pwm, // pwm generator outputs
    input  wire logic             link_error,   // host link error pulse
    input  wire logic             wdt_expired,  // watchdog expiry pulse
    output logic [4:0]            wdt_tap,      // watchdog tap select
    output logic                  fallback_mode,// fallback operation
    output logic [9:0]            fallback_ref, // fallback current ref
    output logic [1:0]            sw_enable,    // channel switching on
    output logic [1:0]            hs_enable,    // high-side switch allowed
    output logic [1:0]            ls_force,     // low-side forced on
    output logic [1:0]            loop_discharge// loop filter discharge
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    alr_cmp_s cmp_meta_reg;
    alr_cmp_s cmp_meta_next;
    alr_cmp_s cmp_reg;
    alr_cmp_s cmp_next;

    always_comb begin
        cmp_meta_next = cmp_pins;
        cmp_next      = cmp_meta_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_meta_reg <= '0;
            cmp_reg      <= '0;
        end else begin
            cmp_meta_reg <= cmp_meta_next;
            cmp_reg      <= cmp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic alr_mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        if (a == ALR_OFS_LIVE1 || a == ALR_OFS_LIVE2) begin
            hit = 1'b1;
        end else if (a == ALR_OFS_ON1 || a == ALR_OFS_OFF1) begin
            hit = 1'b1;
        end else if (a == ALR_OFS_ON2 || a == ALR_OFS_OFF2) begin
            hit = 1'b1;
        end else if (a == ALR_OFS_LBIAS || a == ALR_OFS_FB_LO) begin
            hit = 1'b1;
        end else if (a == ALR_OFS_FB_HI || a == ALR_OFS_HEAT_LO) begin
            hit = 1'b1;
        end else if (a == ALR_OFS_HEAT_HI || a == ALR_OFS_FLAGS1) begin
            hit = 1'b1;
        end else if (a == ALR_OFS_FLAGS2 || a == ALR_OFS_FLAGS3) begin
            hit = 1'b1;
        end else if (a == ALR_OFS_WARN_THR || a == ALR_OFS_WDT_TAP) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    logic setup_rd;
    logic access_done;

    assign setup_rd    = psel & ~penable & ~pwrite;
    assign access_done = psel & penable;
    assign pready      = 1'b1;
    assign pslverr     = access_done & ~alr_mapped(paddr);

    ////////////////////////////////////////////////////////////////////////
    // measurements

    logic [7:0] live_led_voltage_reg [ALR_NCH];
    logic [7:0] live_led_voltage_next [ALR_NCH];
    logic [7:0] led_on_voltage_snapshot_reg [ALR_NCH];
    logic [7:0] led_on_voltage_snapshot_next [ALR_NCH];
    logic [7:0] led_off_voltage_snapshot_reg [ALR_NCH];
    logic [7:0] led_off_voltage_snapshot_next [ALR_NCH];
    logic [1:0] eff_pwm_reg;
    logic [1:0] eff_pwm_next;
    logic [7:0] logic_bias_supply_reg;
    logic [7:0] logic_bias_supply_next;
    logic [9:0] fallback_input_reg;
    logic [9:0] fallback_input_next;
    logic [9:0] heat_raw_reg;
    logic [9:0] heat_raw_next;
    logic [9:0] heat_hold_reg;
    logic [9:0] heat_hold_next;
    logic       adc_hit_led [ALR_NCH];

    assign eff_pwm_next = cmp_reg.dim_pin & internal_pwm; // [R17]

    generate
        for (genvar c = 0; c < ALR_NCH; c++) begin : g_led
            assign adc_hit_led[c] = adc_result.valid &&
                adc_result.src == (c == 0 ? ALR_SRC_LED1 : ALR_SRC_LED2);

            always_comb begin
                live_led_voltage_next[c] = live_led_voltage_reg[c];
                led_on_voltage_snapshot_next[c] =
                    led_on_voltage_snapshot_reg[c];
                led_off_voltage_snapshot_next[c] =
                    led_off_voltage_snapshot_reg[c];
                if (adc_hit_led[c]) begin
                    // eight msbs, two lsbs dropped
                    live_led_voltage_next[c] = adc_result.data[9:2]; // [R1] [R20]
                end
                // copy the value before this update
                if (eff_pwm_reg[c] && !eff_pwm_next[c]) begin
                    led_on_voltage_snapshot_next[c] =
                        live_led_voltage_reg[c]; // [R2]
                end
                if (!eff_pwm_reg[c] && eff_pwm_next[c]) begin
                    led_off_voltage_snapshot_next[c] =
                        live_led_voltage_reg[c]; // [R3]
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    live_led_voltage_reg[c]         <= 8'h00;
                    led_on_voltage_snapshot_reg[c]  <= 8'h00;
                    led_off_voltage_snapshot_reg[c] <= 8'h00;
                end else begin
                    live_led_voltage_reg[c] <= live_led_voltage_next[c];
                    led_on_voltage_snapshot_reg[c] <=
                        led_on_voltage_snapshot_next[c];
                    led_off_voltage_snapshot_reg[c] <=
                        led_off_voltage_snapshot_next[c];
                end
            end
        end
    endgenerate

    always_comb begin
        logic_bias_supply_next = logic_bias_supply_reg;
        fallback_input_next    = fallback_input_reg;
        heat_raw_next          = heat_raw_reg;
        heat_hold_next         = heat_hold_reg;
        if (adc_result.valid) begin
            case (adc_result.src)
                ALR_SRC_LBIAS: logic_bias_supply_next = adc_result.data[9:2]; // [R4] [R20]
                ALR_SRC_FB:    fallback_input_next = adc_result.data; // [R5] [R20]
                ALR_SRC_HEAT:  heat_raw_next = adc_result.data; // [R6] [R20]
                default:       ;
            endcase
        end
        // low-half read freezes both halves
        if (setup_rd && paddr == ALR_OFS_HEAT_LO) begin
            heat_hold_next = heat_raw_reg; // [R7]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            eff_pwm_reg           <= 2'h0;
            logic_bias_supply_reg <= 8'h00;
            fallback_input_reg    <= 10'h000;
            heat_raw_reg          <= 10'h000;
            heat_hold_reg         <= 10'h000;
        end else begin
            eff_pwm_reg           <= eff_pwm_next;
            logic_bias_supply_reg <= logic_bias_supply_next;
            fallback_input_reg    <= fallback_input_next;
            heat_raw_reg          <= heat_raw_next;
            heat_hold_reg         <= heat_hold_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault flags

    logic [ALR_NFLAGS-1:0] flag_cond;
    logic [ALR_NFLAGS-1:0] flag_clr;
    logic [ALR_NFLAGS-1:0] flags;
    logic [7:0]            warning_heat_threshold_reg;
    logic [7:0]            warning_heat_threshold_next;
    logic [4:0]            wdt_tap_reg;
    logic [4:0]            wdt_tap_next;
    logic [1:0]            watchdog_timeout_counter_reg;
    logic [1:0]            watchdog_timeout_counter_next;
    logic                  fallback_reg;
    logic                  fallback_next;
    logic [31:0]           rd_mux;
    logic [31:0]           prdata_reg;
    logic [7:0]            rd_seen_reg;
    logic [7:0]            rd_seen_next;
    logic [7:0]            fault_flags_first;
    logic [7:0]            fault_flags_second;
    logic [7:0]            fault_flags_third;
    logic                  rd_clear;

    always_comb begin
        flag_cond = '0;
        flag_cond[ALR_FB_LOOP_OV +: 2] = cmp_reg.loop_ov; // [R16]
        flag_cond[ALR_FB_TSD +: 2]     = cmp_reg.switch_hot; // [R9]
        flag_cond[ALR_FB_BOOT_UV +: 2] = cmp_reg.boot_uv; // [R15]
        flag_cond[ALR_FB_WARN] =
            heat_raw_reg > {warning_heat_threshold_reg, 2'b00}; // [R8]
        flag_cond[ALR_FB_LINK_ERR]  = link_error; // [R10]
        flag_cond[ALR_FB_ABIAS_UV]  = cmp_reg.analog_uv; // [R13]
        // power-cycle only comes from the reset value
        flag_cond[ALR_FB_PWR_CYC]   = 1'b0; // [R12] [R19]
    end

    assign fault_flags_first  = {6'h00, flags[ALR_FB_LOOP_OV +: 2]};
    assign fault_flags_second = {4'h0, flags[ALR_FB_BOOT_UV +: 2],
                                 flags[ALR_FB_TSD +: 2]};
    assign fault_flags_third  = {2'h0, watchdog_timeout_counter_reg,
                                 flags[ALR_FB_ABIAS_UV],
                                 flags[ALR_FB_PWR_CYC],
                                 flags[ALR_FB_LINK_ERR],
                                 flags[ALR_FB_WARN]};

    // clear only bits read as one; a later event survives
    assign rd_clear = access_done & ~pwrite;

    always_comb begin
        flag_clr = '0;
        if (rd_clear && paddr == ALR_OFS_FLAGS1) begin
            flag_clr[ALR_FB_LOOP_OV +: 2] = rd_seen_reg[1:0]; // [R18]
        end else if (rd_clear && paddr == ALR_OFS_FLAGS2) begin
            flag_clr[ALR_FB_TSD +: 2]     = rd_seen_reg[1:0]; // [R18]
            flag_clr[ALR_FB_BOOT_UV +: 2] = rd_seen_reg[3:2];
        end else if (rd_clear && paddr == ALR_OFS_FLAGS3) begin
            flag_clr[ALR_FB_WARN]     = rd_seen_reg[0]; // [R18]
            flag_clr[ALR_FB_LINK_ERR] = rd_seen_reg[1];
            flag_clr[ALR_FB_PWR_CYC]  = rd_seen_reg[2]; // [R19]
            flag_clr[ALR_FB_ABIAS_UV] = rd_seen_reg[3];
        end
    end

    generate
        for (genvar i = 0; i < ALR_NFLAGS; i++) begin : g_flag
            alr_flag_cell #(
                .RST_VAL (ALR_FLAG_RST[i])
            ) u_flag (
                .clk  (clk),
                .rst  (rst),
                .cond (flag_cond[i]),
                .clr  (flag_clr[i]),
                .flag (flags[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // register access, watchdog count, channel control

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == ALR_OFS_LIVE1) begin
            rd_mux[7:0] = live_led_voltage_reg[0];
        end else if (paddr == ALR_OFS_LIVE2) begin
            rd_mux[7:0] = live_led_voltage_reg[1];
        end else if (paddr == ALR_OFS_ON1) begin
            rd_mux[7:0] = led_on_voltage_snapshot_reg[0];
        end else if (paddr == ALR_OFS_OFF1) begin
            rd_mux[7:0] = led_off_voltage_snapshot_reg[0];
        end else if (paddr == ALR_OFS_ON2) begin
            rd_mux[7:0] = led_on_voltage_snapshot_reg[1];
        end else if (paddr == ALR_OFS_OFF2) begin
            rd_mux[7:0] = led_off_voltage_snapshot_reg[1];
        end else if (paddr == ALR_OFS_LBIAS) begin
            rd_mux[7:0] = logic_bias_supply_reg;
        end else if (paddr == ALR_OFS_FB_LO) begin
            rd_mux[7:0] = fallback_input_reg[7:0]; // [R5]
        end else if (paddr == ALR_OFS_FB_HI) begin
            rd_mux[1:0] = fallback_input_reg[9:8];
        end else if (paddr == ALR_OFS_HEAT_LO) begin
            rd_mux[7:0] = heat_raw_reg[7:0]; // [R7]
        end else if (paddr == ALR_OFS_HEAT_HI) begin
            rd_mux[1:0] = heat_hold_reg[9:8]; // [R6]
        end else if (paddr == ALR_OFS_FLAGS1) begin
            rd_mux[7:0] = fault_flags_first;
        end else if (paddr == ALR_OFS_FLAGS2) begin
            rd_mux[7:0] = fault_flags_second;
        end else if (paddr == ALR_OFS_FLAGS3) begin
            rd_mux[7:0] = fault_flags_third;
        end else if (paddr == ALR_OFS_WARN_THR) begin
            rd_mux[7:0] = warning_heat_threshold_reg;
        end else if (paddr == ALR_OFS_WDT_TAP) begin
            rd_mux[4:0] = wdt_tap_reg;
        end
    end

    always_comb begin
        warning_heat_threshold_next   = warning_heat_threshold_reg;
        wdt_tap_next                  = wdt_tap_reg;
        watchdog_timeout_counter_next = watchdog_timeout_counter_reg;
        fallback_next                 = fallback_reg;
        rd_seen_next                  = rd_seen_reg;
        if (setup_rd) begin
            rd_seen_next = rd_mux[7:0];
        end
        if (access_done && pwrite && paddr == ALR_OFS_WARN_THR) begin
            warning_heat_threshold_next = pwdata[7:0];
        end
        if (access_done && pwrite && paddr == ALR_OFS_WDT_TAP) begin
            wdt_tap_next = pwdata[4:0];
        end
        if (wdt_expired) begin
            fallback_next = 1'b1; // [R11]
            if (watchdog_timeout_counter_reg != ALR_WDT_CNT_MAX) begin
                watchdog_timeout_counter_next =
                    watchdog_timeout_counter_reg + 2'h1; // [R11]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // defaults on bias undervoltage
            warning_heat_threshold_reg   <= ALR_WARN_THR_RST; // [R12]
            wdt_tap_reg                  <= ALR_WDT_TAP_RST;
            watchdog_timeout_counter_reg <= 2'h0;
            fallback_reg                 <= 1'b0;
            rd_seen_reg                  <= 8'h00;
            prdata_reg                   <= 32'h0000_0000;
            sw_enable                    <= 2'h0; // [R12]
            hs_enable                    <= 2'h0;
            ls_force                     <= 2'h0;
            loop_discharge               <= 2'h3; // [R12]
        end else begin
            warning_heat_threshold_reg   <= warning_heat_threshold_next;
            wdt_tap_reg                  <= wdt_tap_next;
            watchdog_timeout_counter_reg <= watchdog_timeout_counter_next;
            fallback_reg                 <= fallback_next;
            rd_seen_reg                  <= rd_seen_next;
            if (setup_rd) begin
                prdata_reg <= rd_mux;
            end
            for (int c = 0; c < ALR_NCH; c++) begin
                // overheat and dimming uv act per channel only
                sw_enable[c] <= ~cmp_reg.switch_hot[c] & ~cmp_reg.dim_uv[c]
                                & ~cmp_reg.analog_uv; // [R9] [R13] [R14]
                hs_enable[c] <= ~cmp_reg.switch_hot[c] & ~cmp_reg.dim_uv[c]
                                & ~cmp_reg.analog_uv
                                & ~cmp_reg.boot_uv[c]; // [R15]
                ls_force[c]  <= cmp_reg.boot_uv[c]; // [R15]
                loop_discharge[c] <= cmp_reg.analog_uv; // [R13]
            end
        end
    end

    assign prdata        = prdata_reg;
    assign wdt_tap       = wdt_tap_reg;
    assign fallback_mode = fallback_reg; // [R11]
    assign fallback_ref  = fallback_input_reg; // [R5]

endmodule // alr_top

`default_nettype wire

// File: dv/alr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module alr_checker
    import alr_pkg::*;
(
    input  wire logic       clk,           // clock
    input  wire logic       rst,           // reset
    input  wire alr_adc_s   adc_result,    // adc result
    input  wire alr_cmp_s   cmp_pins,      // comparators
    input  wire logic       wdt_expired,   // watchdog pulse
    input  wire logic       fallback_mode, // fallback state
    input  wire logic [9:0] fallback_ref,  // fallback ref
    input  wire logic [1:0] sw_enable,     // switching on
    input  wire logic [1:0] hs_enable,     // high side
    input  wire logic [1:0] ls_force,      // low side
    input  wire logic [1:0] loop_discharge // discharge
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    sequence s_fb;
        adc_result.valid && adc_result.src == ALR_SRC_FB;
    endsequence
    property p_fb;
        s_fb |=> fallback_ref == $past(adc_result.data);
    endproperty
    property p_wdt;
        wdt_expired |=> fallback_mode;
    endproperty
    property p_hold;
        fallback_mode |=> fallback_mode;
    endproperty
    property p_rel;
        $fell(rst) |-> !fallback_mode && fallback_ref == 10'h000;
    endproperty
    property p_tsd;
        cmp_pins.switch_hot[0] [*4] |-> !sw_enable[0];
    endproperty
    property p_duv;
        cmp_pins.dim_uv[1] [*4] |-> !sw_enable[1];
    endproperty
    property p_boot;
        cmp_pins.boot_uv[0] [*4] |-> !hs_enable[0] && ls_force[0];
    endproperty
    property p_auv;
        cmp_pins.analog_uv [*4] |-> !sw_enable && &loop_discharge;
    endproperty
    a_fb: assert property (p_fb) else $error("fallback ref wrong");
    a_wdt: assert property (p_wdt) else $error("no fallback");
    a_hold: assert property (p_hold) else $error("fallback left");
    a_rel: assert property (p_rel) else $error("reset values");
    a_tsd: assert property (p_tsd) else $error("hot still on");
    a_duv: assert property (p_duv) else $error("uv still on");
    a_boot: assert property (p_boot) else $error("boot uv drive");
    a_auv: assert property (p_auv) else $error("bias uv drive");
endmodule // alr_checker
`default_nettype wire

// File: dv/alr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module alr_host_model (
    input  wire logic        clk,     // clock
    input  wire logic        pready,  // ready
    input  wire logic [31:0] prdata,  // read data
    input  wire logic        pslverr, // error
    output logic             psel,    // select
    output logic             penable, // access
    output logic             pwrite,  // direction
    output logic [7:0]       paddr,   // address
    output logic [31:0]      pwdata   // write data
);
    logic err;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // alr_host_model
`default_nettype wire

// File: dv/alr_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module alr_tb_top
    import alr_pkg::*;
;
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic link_error, wdt_expired, fallback_mode;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    alr_adc_s adc_result;
    alr_cmp_s cmp_pins;
    logic [1:0] internal_pwm, sw_enable, hs_enable, ls_force, loop_discharge;
    logic [4:0] wdt_tap;
    logic [9:0] fallback_ref, v;
    logic [31:0] seed = 32'h0000_41d3;
    int num_errors = 0;
    int checked = 0;
    alr_top dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .adc_result, .cmp_pins, .internal_pwm,
        .link_error, .wdt_expired, .wdt_tap, .fallback_mode, .fallback_ref,
        .sw_enable, .hs_enable, .ls_force, .loop_discharge);
    alr_host_model host_u (.clk, .pready, .prdata, .pslverr, .psel,
        .penable, .pwrite, .paddr, .pwdata);
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] code8(logic [9:0] d);
        return {24'h0000_00, d[9:2]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        host_u.xfer(1'b0, a, 32'h0000_0000, rd);
        chk(rd, e);
    endtask
    task automatic adc(input alr_src_e s, input logic [9:0] d);
        @(posedge clk);
        adc_result <= {1'b1, s, d};
        @(posedge clk);
        adc_result.valid <= 1'b0;
    endtask
    task automatic hold(input alr_cmp_s c);
        @(posedge clk);
        cmp_pins <= c ^ 11'h600;
        repeat (8) @(posedge clk);
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        {link_error, wdt_expired, adc_result} = '0;
        rst = 1'b1;
        internal_pwm = 2'b11;
        cmp_pins = '{dim_pin: 2'b11, default: '0};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc(ALR_OFS_FLAGS3, 32'h0000_0004);
        rdc(ALR_OFS_FLAGS3, 32'h0000_0000);
        chk({27'h0, wdt_tap}, 32'h0000_0018);
        rdc(ALR_OFS_WARN_THR, 32'h0000_0080);
        rdc(8'h40, 32'h0000_0000);
        chk({31'h0, host_u.err}, 32'h0000_0001);
        repeat (4) begin
            v = 10'(rnd());
            adc(ALR_SRC_LED1, v);
            rdc(ALR_OFS_LIVE1, code8(v));
            adc(ALR_SRC_LED2, ~v);
            rdc(ALR_OFS_LIVE2, code8(~v));
            adc(ALR_SRC_LBIAS, v);
            rdc(ALR_OFS_LBIAS, code8(v));
            adc(ALR_SRC_FB, v);
            rdc(ALR_OFS_FB_LO, {24'h0, v[7:0]});
            rdc(ALR_OFS_FB_HI, {30'h0, v[9:8]});
            chk(32'(fallback_ref), 32'(v));
            adc(ALR_SRC_OTHER, ~v);
            rdc(ALR_OFS_LIVE1, code8(v));
        end
        @(posedge clk);
        internal_pwm <= 2'b10;
        repeat (4) @(posedge clk);
        rdc(ALR_OFS_ON1, code8(v));
        adc(ALR_SRC_LED1, ~v);
        internal_pwm <= 2'b11;
        repeat (4) @(posedge clk);
        rdc(ALR_OFS_OFF1, code8(~v));
        hold('{dim_pin: 2'b10, default: '0});
        rdc(ALR_OFS_ON2, code8(~v));
        v = {1'b1, 9'(rnd())} | 10'h001;
        adc(ALR_SRC_HEAT, v);
        rdc(ALR_OFS_HEAT_LO, {24'h0, v[7:0]});
        adc(ALR_SRC_HEAT, 10'h000);
        rdc(ALR_OFS_HEAT_HI, {30'h0, v[9:8]});
        rdc(ALR_OFS_FLAGS3, 32'h0000_0001);
        host_u.xfer(1'b1, ALR_OFS_WARN_THR, 32'h0000_0010, rd);
        adc(ALR_SRC_HEAT, 10'h040);
        rdc(ALR_OFS_FLAGS3, 32'h0000_0000);
        repeat (4) begin
            @(posedge clk);
            {link_error, wdt_expired} <= 2'b11;
            @(posedge clk);
            {link_error, wdt_expired} <= 2'b00;
        end
        chk({31'h0, fallback_mode}, 32'h0000_0001);
        rdc(ALR_OFS_FLAGS3, 32'h0000_0032);
        rdc(ALR_OFS_FLAGS3, 32'h0000_0030);
        hold('{loop_ov: 2'b10, default: '0});
        rdc(ALR_OFS_FLAGS1, 32'h0000_0002);
        hold('{switch_hot: 2'b01, default: '0});
        rdc(ALR_OFS_FLAGS2, 32'h0000_0001);
        hold('{boot_uv: 2'b01, default: '0});
        rdc(ALR_OFS_FLAGS2, 32'h0000_0005);
        rdc(ALR_OFS_FLAGS2, 32'h0000_0004);
        hold('{dim_uv: 2'b10, default: '0});
        hold('{analog_uv: 1'b1, default: '0});
        rdc(ALR_OFS_FLAGS3, 32'h0000_0038);
        hold('0);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(ALR_OFS_FLAGS3, 32'h0000_0004);
        chk({31'h0, fallback_mode}, 32'h0000_0000);
        end_of_test();
    end
endmodule // alr_tb_top
bind alr_top alr_checker chk_u (.clk, .rst, .adc_result, .cmp_pins,
    .wdt_expired, .fallback_mode, .fallback_ref, .sw_enable, .hs_enable,
    .ls_force, .loop_discharge);
`default_nettype wire

// File: inc/alr_pkg.sv
package alr_pkg;

    localparam int ALR_NCH = 2;

    // apb register byte offsets
    localparam logic [7:0] ALR_OFS_LIVE1    = 8'h00;
    localparam logic [7:0] ALR_OFS_LIVE2    = 8'h04;
    localparam logic [7:0] ALR_OFS_ON1      = 8'h08;
    localparam logic [7:0] ALR_OFS_OFF1     = 8'h0C;
    localparam logic [7:0] ALR_OFS_ON2      = 8'h10;
    localparam logic [7:0] ALR_OFS_OFF2     = 8'h14;
    localparam logic [7:0] ALR_OFS_LBIAS    = 8'h18;
    localparam logic [7:0] ALR_OFS_FB_LO    = 8'h1C;
    localparam logic [7:0] ALR_OFS_FB_HI    = 8'h20;
    localparam logic [7:0] ALR_OFS_HEAT_LO  = 8'h24;
    localparam logic [7:0] ALR_OFS_HEAT_HI  = 8'h28;
    localparam logic [7:0] ALR_OFS_FLAGS1   = 8'h2C;
    localparam logic [7:0] ALR_OFS_FLAGS2   = 8'h30;
    localparam logic [7:0] ALR_OFS_FLAGS3   = 8'h34;
    localparam logic [7:0] ALR_OFS_WARN_THR = 8'h38;
    localparam logic [7:0] ALR_OFS_WDT_TAP  = 8'h3C;

    // positions in the flag vector (one sticky cell each)
    localparam int ALR_FB_LOOP_OV  = 0;  // two bits, first flags [1:0]
    localparam int ALR_FB_TSD      = 2;  // two bits, second flags [1:0]
    localparam int ALR_FB_BOOT_UV  = 4;  // two bits, second flags [3:2]
    localparam int ALR_FB_WARN     = 6;  // third flags bit 0
    localparam int ALR_FB_LINK_ERR = 7;  // third flags bit 1
    localparam int ALR_FB_PWR_CYC  = 8;  // third flags bit 2
    localparam int ALR_FB_ABIAS_UV = 9;  // third flags bit 3
    localparam int ALR_NFLAGS      = 10;
    localparam int ALR_F3_WDT_LSB  = 4;  // third flags [5:4]

    // reset values
    localparam logic [ALR_NFLAGS-1:0] ALR_FLAG_RST = 10'h100;
    localparam logic [7:0]  ALR_WARN_THR_RST = 8'h80;
    localparam logic [4:0]  ALR_WDT_TAP_RST  = 5'h18;
    localparam logic [1:0]  ALR_WDT_CNT_MAX  = 2'h3;

    typedef enum logic [2:0] {
        ALR_SRC_LED1  = 3'b000,
        ALR_SRC_LED2  = 3'b001,
        ALR_SRC_LBIAS = 3'b010,
        ALR_SRC_FB    = 3'b011,
        ALR_SRC_HEAT  = 3'b100,
        ALR_SRC_OTHER = 3'b111
    } alr_src_e;

    typedef struct packed {
        logic       valid;
        alr_src_e   src;
        logic [9:0] data;
    } alr_adc_s;

    // raw comparator / pin levels, asynchronous to clk
    typedef struct packed {
        logic [1:0] dim_pin;
        logic [1:0] switch_hot;
        logic [1:0] dim_uv;
        logic [1:0] boot_uv;
        logic [1:0] loop_ov;
        logic       analog_uv;
    } alr_cmp_s;

endpackage
